// ### common/tpa_pkg.sv
// Constants, types and decode helpers shared by the touch alert logic.
// Assumes a command word sent MSB first, start bit at the top.
package tpa_pkg;

   // ************************************************************
   // Command word layout
   // ************************************************************
   localparam int unsigned CMD_W     = 8;
   localparam int unsigned CH_HI     = 6;
   localparam int unsigned CH_LO     = 4;
   localparam int unsigned PD1_POS   = 1;
   localparam int unsigned PD0_POS   = 0;
   localparam logic [7:0]  CMD_RESET = 8'h00;

   // ************************************************************
   // Frame positions, counted in serial clock edges
   // ************************************************************
   localparam int unsigned RCNT_W    = 4;
   localparam logic [3:0]  RISE_CH   = 4'h4;
   localparam logic [3:0]  RISE_REF  = 4'h7;
   localparam logic [3:0]  RISE_CMD  = 4'h8;
   localparam logic [3:0]  RISE_MAX  = 4'hF;
   localparam int unsigned FCNT_W    = 5;
   localparam logic [4:0]  FALL_CONV = 5'h05;
   localparam logic [4:0]  FALL_LATE = 5'h14;

   // ************************************************************
   // Channel codes that drive the plates
   // ************************************************************
   localparam logic [2:0]  CH_Y      = 3'h1;
   localparam logic [2:0]  CH_Z1     = 3'h3;
   localparam logic [2:0]  CH_Z2     = 3'h4;
   localparam logic [2:0]  CH_X      = 3'h5;

   // Gray order, so the two synchronised bits show no false phase while the phase advances.
   typedef enum logic [1:0] {
      PH_EARLY = 2'b00,
      PH_CONV  = 2'b01,
      PH_LATE  = 2'b11
   } tpa_phase_e;

   typedef enum logic [1:0] {
      EV_CH  = 2'b00,
      EV_REF = 2'b01,
      EV_CMD = 2'b10
   } tpa_event_e;

   typedef struct packed {
      logic [2:0] ch;
      logic       pd1;
      logic       pd0;
   } tpa_cmd_s;

   // Position and pressure measurements both drive the plates.
   function automatic logic tpa_is_position(input logic [2:0] ch);
      return (ch == CH_X) || (ch == CH_Y) || (ch == CH_Z1) || (ch == CH_Z2);
   endfunction

endpackage

// ### design/tpa_frame_tracker.sv
// Falling-edge counter of the serial clock within one frame.
// Assumes the frame reset is high whenever chip select is high.
`timescale 1ns/1ps
`default_nettype none
module tpa_frame_tracker
   import tpa_pkg::*;
(
   input  wire logic       serial_shift_clock,
   input  wire logic       frame_rst,
   input  wire logic       started,
   output var  tpa_phase_e phase
);

   typedef struct packed {
      logic [4:0] fall_cnt;
      tpa_phase_e phase;
   } tpa_track_s;

   tpa_track_s r;
   tpa_track_s nxt;

   // ************************************************************
   // Phase from the falling edge count
   // ************************************************************
   always_comb begin
      nxt = r;
      if (started && (r.fall_cnt != FALL_LATE)) begin
         nxt.fall_cnt = r.fall_cnt + 5'h01; // RULE_17
      end
      if (nxt.fall_cnt >= FALL_LATE) begin
         nxt.phase = PH_LATE;
      end else if (nxt.fall_cnt >= FALL_CONV) begin
         nxt.phase = PH_CONV;
      end else begin
         nxt.phase = PH_EARLY;
      end
   end

   always_ff @(negedge serial_shift_clock or posedge frame_rst) begin
      if (frame_rst) begin
         r <= '{fall_cnt: 5'h00, phase: PH_EARLY};
      end else begin
         r <= nxt;
      end
   end

   assign phase = r.phase;

endmodule
`default_nettype wire

// ### design/tpa_alert_core.sv
// Pen-touch alert logic of a serial controlled touch screen converter.
// Assumes the host drives chip select, serial clock and serial data in.
//
// Behaviour
// RULE_01: Pen detect grounds y-minus, pulls x-plus.
// RULE_02: Chip select high: touch lowers alert.
// RULE_03: Converter power bit loads at 8th rise.
// RULE_04: Conversion interval: alert by channel kind.
// RULE_05: Early interval, bit clear: alert follows touch.
// RULE_06: Early interval, bit set: last channel decides.
// RULE_07: Late interval, bit clear: alert follows touch.
// RULE_08: Late interval, bit set: current channel decides.
// RULE_09: Reference power follows reference bit only.
// RULE_10: Host ignores alert during command, data.
// RULE_11: Full power down clears command, alert high.
// RULE_12: Host sends one command after power-up.
// RULE_13: Last command state held until next.
// RULE_14: Command shifts in from first high bit.
// RULE_15: Reference bit loads at 7th rise.
// RULE_16: Both bits set: alert high, detect off.
// RULE_17: Falling edges counted to find intervals.
`timescale 1ns/1ps
`default_nettype none
module tpa_alert_core
   import tpa_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic serial_shift_clock,
   input  wire logic chip_select_n,
   input  wire logic serial_data_in,
   input  wire logic touch_pressed,
   output logic      touch_alert_n,
   output logic      y_minus_ground_en,
   output logic      x_plus_pullup_en,
   output logic      plates_float,
   output logic      reference_power_on
);

   // ************************************************************
   // Link side: command shifter on the serial clock
   // ************************************************************
   typedef struct packed {
      logic       started;
      logic [3:0] rise_cnt;
      logic [7:0] shift;
      logic       tog;
      tpa_event_e ev_kind;
      logic [7:0] ev_word;
   } tpa_link_s;

   tpa_link_s  lr;
   tpa_link_s  ln;
   tpa_link_s  frame_r;
   tpa_link_s  event_r;
   logic       frame_rst;
   tpa_phase_e link_phase;

   // Chip select high ends the frame even though the clock may stop.
   assign frame_rst = rst | chip_select_n;

   always_comb begin
      ln = lr;
      if (!lr.started) begin
         if (serial_data_in) begin
            ln.started  = 1'b1; // RULE_14
            ln.shift    = 8'h01;
            ln.rise_cnt = 4'h1;
         end
      end else begin
         ln.shift = {lr.shift[6:0], serial_data_in};
         if (lr.rise_cnt != RISE_MAX) begin
            ln.rise_cnt = lr.rise_cnt + 4'h1;
         end
      end
      // Each event flips the toggle; word and kind then stand for a
      // whole serial clock, far longer than the crossing takes.
      if (ln.started && (ln.rise_cnt != lr.rise_cnt)) begin
         if (ln.rise_cnt == RISE_CH) begin
            ln.tog     = ~lr.tog;
            ln.ev_kind = EV_CH;
            ln.ev_word = ln.shift;
         end else if (ln.rise_cnt == RISE_REF) begin
            ln.tog     = ~lr.tog; // RULE_15
            ln.ev_kind = EV_REF;
            ln.ev_word = ln.shift;
         end else if (ln.rise_cnt == RISE_CMD) begin
            ln.tog     = ~lr.tog; // RULE_03
            ln.ev_kind = EV_CMD;
            ln.ev_word = ln.shift;
         end
      end
   end

   // The two halves of the link state have different resets, so each lives
   // in a register of its own and the unused half of each copy is dropped.
   always_comb begin
      lr         = frame_r;
      lr.tog     = event_r.tog;
      lr.ev_kind = event_r.ev_kind;
      lr.ev_word = event_r.ev_word;
   end

   always_ff @(posedge serial_shift_clock or posedge frame_rst) begin
      if (frame_rst) begin
         frame_r <= '{started: 1'b0, rise_cnt: 4'h0, shift: CMD_RESET,
                      tog: 1'b0, ev_kind: EV_CH, ev_word: CMD_RESET};
      end else begin
         frame_r <= ln;
      end
   end

   // The toggle is left alone by the frame reset so no event is lost.
   always_ff @(posedge serial_shift_clock or posedge rst) begin
      if (rst) begin
         event_r <= '{started: 1'b0, rise_cnt: 4'h0, shift: CMD_RESET,
                      tog: 1'b0, ev_kind: EV_CH, ev_word: CMD_RESET};
      end else begin
         event_r <= ln;
      end
   end

   // Zero bits ahead of the start bit must leave the frame unstarted.
   a_start_bit: assert property ( // RULE_14
      @(posedge serial_shift_clock) disable iff (frame_rst)
      !lr.started && !serial_data_in |=> !lr.started)
      else $error("frame started without a start bit");

   tpa_frame_tracker u_tracker (
      .serial_shift_clock (serial_shift_clock),
      .frame_rst          (frame_rst),
      .started            (lr.started),
      .phase              (link_phase)
   );

   // ************************************************************
   // Core side: synchronisers, command state and alert
   // ************************************************************
   typedef struct packed {
      logic [1:0] cs_s;
      logic [1:0] din_s;
      logic [1:0] touch_s;
      logic [1:0] tog_s;
      logic [1:0] ph0_s;
      logic [1:0] ph1_s;
      logic       tog_seen;
      tpa_cmd_s   cmd;
      logic [2:0] new_ch;
      logic       alert_n;
      logic       pen_en;
      logic       float_p;
   } tpa_core_s;

   tpa_core_s  r;
   tpa_core_s  n;
   logic       cs_hi;
   logic       fpd;
   logic       touch;
   logic       ev;
   logic       both_pd;
   tpa_phase_e ph;

   assign cs_hi   = r.cs_s[1];
   assign fpd     = r.cs_s[1] & r.din_s[1];
   assign touch   = r.touch_s[1];
   assign ev      = r.tog_s[1] ^ r.tog_seen;
   assign both_pd = r.cmd.pd1 & r.cmd.pd0;
   assign ph      = tpa_phase_e'({r.ph1_s[1], r.ph0_s[1]});
   // Late returns to early in two bits at once when chip select rises; a
   // one-cycle mix is possible in silicon, which the host ignores as noise.

   always_comb begin
      n          = r;
      n.cs_s     = {r.cs_s[0], chip_select_n};
      n.din_s    = {r.din_s[0], serial_data_in};
      n.touch_s  = {r.touch_s[0], touch_pressed};
      n.tog_s    = {r.tog_s[0], lr.tog};
      n.ph0_s    = {r.ph0_s[0], link_phase[0]};
      n.ph1_s    = {r.ph1_s[0], link_phase[1]};
      n.tog_seen = r.tog_s[1];
      // Full power down wins over a load in the same cycle, so a command
      // cut short by a power-down request is dropped rather than half kept.
      if (fpd) begin
         n.cmd    = tpa_cmd_s'(5'(CMD_RESET)); // RULE_11
         n.new_ch = CMD_RESET[2:0];
      end else if (ev) begin
         if (lr.ev_kind == EV_CH) begin
            n.new_ch = lr.ev_word[2:0];
         end else if (lr.ev_kind == EV_REF) begin
            n.cmd.pd1 = lr.ev_word[0]; // RULE_15
         end else begin
            n.cmd.ch  = lr.ev_word[CH_HI:CH_LO]; // RULE_13
            n.cmd.pd1 = lr.ev_word[PD1_POS];
            n.cmd.pd0 = lr.ev_word[PD0_POS]; // RULE_03
            n.new_ch  = lr.ev_word[CH_HI:CH_LO];
         end
      end
      // Outputs are decided from the held command, not the new one.
      n.pen_en  = 1'b0;
      n.float_p = 1'b0;
      if (cs_hi) begin
         if (fpd) begin
            n.alert_n = 1'b1; // RULE_11
            n.float_p = 1'b1;
         end else if (both_pd) begin
            n.alert_n = 1'b1; // RULE_16
         end else begin
            n.alert_n = ~touch; // RULE_02
            n.pen_en  = 1'b1; // RULE_01
         end
      end else if (ph == PH_CONV) begin
         n.alert_n = ~tpa_is_position(r.new_ch); // RULE_04
      end else if (!r.cmd.pd0) begin
         n.alert_n = ~touch; // RULE_05 RULE_07
         n.pen_en  = 1'b1;
      end else begin
         n.alert_n = ~tpa_is_position(r.cmd.ch); // RULE_06 RULE_08
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         r <= '{cs_s: 2'h3, din_s: 2'h0, touch_s: 2'h0, tog_s: 2'h0,
                ph0_s: 2'h0, ph1_s: 2'h0, tog_seen: 1'b0,
                cmd: tpa_cmd_s'(5'(CMD_RESET)), new_ch: 3'h0,
                alert_n: 1'b1, pen_en: 1'b0, float_p: 1'b0};
      end else begin
         r <= n;
      end
   end

   assign touch_alert_n      = r.alert_n;
   assign y_minus_ground_en  = r.pen_en; // RULE_01
   assign x_plus_pullup_en   = r.pen_en;
   assign plates_float       = r.float_p;
   assign reference_power_on = r.cmd.pd1; // RULE_09

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   a_cs_high_touch: assert property ( // RULE_02
      cs_hi && !fpd && !both_pd && touch |=> !touch_alert_n && x_plus_pullup_en)
      else $error("alert not low on touch with chip select high");

   a_both_pd_high: assert property ( // RULE_16
      cs_hi && both_pd |=> touch_alert_n && !y_minus_ground_en)
      else $error("alert not forced high with both power bits set");

   a_conv_forced: assert property ( // RULE_04
      !cs_hi && ph == PH_CONV |=> touch_alert_n == !tpa_is_position($past(r.new_ch)))
      else $error("conversion interval alert wrong");

   a_early_follow: assert property ( // RULE_05
      !cs_hi && ph == PH_EARLY && !r.cmd.pd0 |=> touch_alert_n == !$past(touch))
      else $error("early alert does not follow touch");

   a_early_held: assert property ( // RULE_06
      !cs_hi && ph == PH_EARLY && r.cmd.pd0 && tpa_is_position(r.cmd.ch)
      |=> !touch_alert_n)
      else $error("early alert not held low");

   a_late_follow: assert property ( // RULE_07
      !cs_hi && ph == PH_LATE && !r.cmd.pd0 |=> touch_alert_n == !$past(touch))
      else $error("late alert does not follow touch");

   a_late_held: assert property ( // RULE_08
      !cs_hi && ph == PH_LATE && r.cmd.pd0 && !tpa_is_position(r.cmd.ch)
      |=> touch_alert_n)
      else $error("late alert not held high");

   a_full_pd: assert property ( // RULE_11
      fpd |=> r.cmd == tpa_cmd_s'(5'h00) && touch_alert_n && plates_float)
      else $error("full power down did not clear state");

   a_pd0_moment: assert property ( // RULE_03
      !fpd && !(ev && lr.ev_kind == EV_CMD) |=> $stable(r.cmd.pd0) && $stable(r.cmd.ch))
      else $error("converter power bit changed off the 8th edge");

   a_ref_follow: assert property ( // RULE_09
      !fpd && !(ev && lr.ev_kind != EV_CH) |=> $stable(reference_power_on))
      else $error("reference power moved without a reference bit load");

   a_ref_load: assert property ( // RULE_15
      !fpd && ev && lr.ev_kind == EV_REF |=> reference_power_on == $past(lr.ev_word[0]))
      else $error("reference bit not taken at the 7th rise");

   a_cmd_load: assert property ( // RULE_13
      !fpd && ev && lr.ev_kind == EV_CMD
      |=> r.cmd.ch == $past(lr.ev_word[CH_HI:CH_LO]) && r.cmd.pd0 == $past(lr.ev_word[PD0_POS]))
      else $error("command not stored at the 8th rise");

   a_ch_capture: assert property ( // RULE_04
      !fpd && ev && lr.ev_kind == EV_CH |=> r.new_ch == $past(lr.ev_word[2:0]))
      else $error("channel not captured at the 4th rise");

   a_float_fpd: assert property ( // RULE_11
      !fpd |=> !plates_float)
      else $error("plates floated outside full power down");

   a_pen_conv_off: assert property ( // RULE_01
      !cs_hi && ph == PH_CONV |=> !y_minus_ground_en && !x_plus_pullup_en)
      else $error("pen detect left on during conversion");

   a_early_pen: assert property ( // RULE_05
      !cs_hi && ph == PH_EARLY && !r.cmd.pd0 |=> y_minus_ground_en && x_plus_pullup_en)
      else $error("pen detect off in early interval");

   a_late_pen: assert property ( // RULE_07
      !cs_hi && ph == PH_LATE && !r.cmd.pd0 |=> y_minus_ground_en && x_plus_pullup_en)
      else $error("pen detect off in late interval");

   a_cs_high_idle: assert property ( // RULE_02
      cs_hi && !fpd && !both_pd && !touch |=> touch_alert_n)
      else $error("alert low without touch with chip select high");

   a_early_high: assert property ( // RULE_06
      !cs_hi && ph == PH_EARLY && r.cmd.pd0 && !tpa_is_position(r.cmd.ch)
      |=> touch_alert_n)
      else $error("early alert not held high");

   a_late_low: assert property ( // RULE_08
      !cs_hi && ph == PH_LATE && r.cmd.pd0 && tpa_is_position(r.cmd.ch)
      |=> !touch_alert_n)
      else $error("late alert not held low");

   // The edge count saturates, so within one frame the phase only advances.
   a_phase_late: assert property ( // RULE_17
      !cs_hi && ph == PH_LATE ##1 !cs_hi |-> ph == PH_LATE)
      else $error("late phase left while chip select low");

   a_phase_conv: assert property ( // RULE_17
      !cs_hi && ph == PH_CONV ##1 !cs_hi |-> ph != PH_EARLY)
      else $error("phase fell back to early within a frame");

   c_touch_idle: cover property (cs_hi && touch ##1 !touch_alert_n);
   c_conv_seen:  cover property (!cs_hi && ph == PH_CONV ##[1:400] ph == PH_LATE);
   c_full_pd:    cover property (fpd ##1 plates_float);
   c_cmd_load:   cover property (ev && lr.ev_kind == EV_CMD);
   c_late_touch: cover property (!cs_hi && ph == PH_LATE && !r.cmd.pd0 && touch);

endmodule
`default_nettype wire

// ### testbench/tpa_host_model.sv
// Host model: drives chip select, serial clock and command data in.
// Assumes the bench calls its tasks one at a time from one process.
`timescale 1ns/1ps
`default_nettype none
module tpa_host_model
   import tpa_pkg::*;
(
   output logic chip_select_n,
   output logic serial_shift_clock,
   output logic serial_data_in
);
   logic [7:0] word;
   int         pos;

   initial begin
      chip_select_n      = 1'b1;
      serial_shift_clock = 1'b0;
      serial_data_in     = 1'b0;
      pos                = 0;
   end

   // *************************************************
   // Frame tasks
   // *************************************************
   // The clock stands low between calls, so the bench can look at the alert
   // at a fixed frame position. Data changes only after a falling edge.
   task automatic clocks(input int upto);
      while (pos < upto) begin
         pos++;
         serial_data_in = (pos >= 1 && pos <= 8) ? word[8-pos] : 1'b0;
         #80 serial_shift_clock = 1'b1;
         #80 serial_shift_clock = 1'b0;
      end
   endtask

   // The alert is never read here, which keeps frame noise out of the host.
   task automatic open(input logic [7:0] cmd, input int lead, input int upto);
      word = cmd;
      pos  = -lead;
      #7 chip_select_n = 1'b0;
      #80;
      clocks(upto);
   endtask

   task automatic close();
      #80 chip_select_n = 1'b1;
   endtask

   task automatic idle(input logic v);
      serial_data_in = v;
   endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the touch alert logic.
// Assumes the host model is the only driver of the serial pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tpa_pkg::*;
   logic ref_clk       = 1'b0;
   logic rst;
   logic touch_pressed;
   wire  cs_n;
   wire  sclk;
   wire  din;
   logic alert_n;
   logic gnd_en;
   logic pull_en;
   logic flt;
   logic ref_on;
   int   failures      = 0;
   int   checks_done   = 0;

   always #4 ref_clk = ~ref_clk;

   tpa_host_model host (
      .chip_select_n     (cs_n),
      .serial_shift_clock(sclk),
      .serial_data_in    (din)
   );

   tpa_alert_core uut (
      .ref_clk           (ref_clk),
      .rst               (rst),
      .serial_shift_clock(sclk),
      .chip_select_n     (cs_n),
      .serial_data_in    (din),
      .touch_pressed     (touch_pressed),
      .touch_alert_n     (alert_n),
      .y_minus_ground_en (gnd_en),
      .x_plus_pullup_en  (pull_en),
      .plates_float      (flt),
      .reference_power_on(ref_on)
   );

   // *************************************************
   // Helpers
   // *************************************************
   task automatic finish_test();
      if (failures == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic cmp(input string nm, input logic got, input logic e);
      checks_done++;
      if (got !== e) begin
         failures++;
         $display("BAD %s expected %b seen %b", nm, e, got);
      end
   endtask

   // Eight cycles cover the two-stage sync plus the output register.
   task automatic want(input string nm, ref logic s, input logic e);
      repeat (8) @(posedge ref_clk);
      cmp(nm, s, e);
   endtask

   task automatic touch(input logic v);
      @(posedge ref_clk);
      touch_pressed <= v;
   endtask

   // *************************************************
   // Scenarios
   // *************************************************
   task automatic idle_defaults();
      touch(1'b1);
      want("alert", alert_n, 1'b0);
      cmp("ground", gnd_en, 1'b1);
      cmp("pullup", pull_en, 1'b1);
      touch(1'b0);
      want("alert", alert_n, 1'b1);
   endtask

   task automatic x_frame();
      host.open(8'hD1, 0, 3);
      touch(1'b1);
      want("alert", alert_n, 1'b0);
      touch(1'b0);
      want("alert", alert_n, 1'b1);
      host.clocks(10);
      want("alert", alert_n, 1'b0);
      host.clocks(20);
      want("alert", alert_n, 1'b0);
      host.close();
      want("alert", alert_n, 1'b1);
   endtask

   task automatic temp_frame();
      host.open(8'h83, 0, 3);
      want("alert", alert_n, 1'b0);
      host.clocks(7);
      want("refpwr", ref_on, 1'b1);
      touch(1'b1);
      want("alert", alert_n, 1'b1);
      host.clocks(20);
      want("alert", alert_n, 1'b1);
      host.close();
      want("alert", alert_n, 1'b1);
      cmp("ground", gnd_en, 1'b0);
      cmp("refpwr", ref_on, 1'b1);
   endtask

   task automatic y_frame_lead_zeros();
      host.open(8'h92, 2, 3);
      want("alert", alert_n, 1'b1);
      host.clocks(20);
      want("alert", alert_n, 1'b0);
      touch(1'b0);
      want("alert", alert_n, 1'b1);
      host.close();
      touch(1'b1);
      want("alert", alert_n, 1'b0);
      cmp("refpwr", ref_on, 1'b1);
   endtask

   task automatic full_power_down();
      host.idle(1'b1);
      want("alert", alert_n, 1'b1);
      cmp("float", flt, 1'b1);
      cmp("refpwr", ref_on, 1'b0);
      host.idle(1'b0);
      want("alert", alert_n, 1'b0);
      cmp("float", flt, 1'b0);
   endtask

   // *************************************************
   // Main sequence
   // *************************************************
   initial begin
      rst           <= 1'b1;
      touch_pressed <= 1'b0;
      repeat (3) @(posedge ref_clk);
      cmp("alert", alert_n, 1'b1);
      cmp("float", flt, 1'b0);
      cmp("refpwr", ref_on, 1'b0);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      idle_defaults();
      x_frame();
      temp_frame();
      y_frame_lead_zeros();
      full_power_down();
      finish_test();
   end
endmodule
`default_nettype wire
